// ### logic/riot_pkg.sv
// Purpose: Shared constants and carrier types for the I/O and interval timer block.
// Assumes: Bus sampled on the i_clk edge that stands for the phase-two edge.
// Notes: Address bits are indices into the 7-bit address bus.
package riot_pkg;
    // =====================================================================
    // Address field positions
    // =====================================================================
    localparam int ADDR_W = 7;
    localparam int A0_BIT = 0;
    localparam int A1_BIT = 1;
    localparam int A2_BIT = 2;
    localparam int A3_BIT = 3;
    localparam int A4_BIT = 4;
    // Port register selection by A1..A0.
    localparam logic [1:0] SEL_PORT_A_OUTPUT = 2'h0;
    localparam logic [1:0] SEL_PORT_A_DIRECTION = 2'h1;
    localparam logic [1:0] SEL_PORT_B_OUTPUT = 2'h2;
    localparam logic [1:0] SEL_PORT_B_DIRECTION = 2'h3;
    // =====================================================================
    // Flag register layout and reset values
    // =====================================================================
    localparam int TIMER_FLAG_BIT = 7;
    localparam int EDGE_FLAG_BIT = 6;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    // =====================================================================
    // Prescale choices: one, eight, sixty-four and 1024 periods per interval
    // =====================================================================
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_8 = 2'h1;
    localparam logic [1:0] DIV_64 = 2'h2;
    localparam logic [1:0] DIV_1024 = 2'h3;
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV_1_LAST = 10'h000;
    localparam logic [9:0] DIV_8_LAST = 10'h007;
    localparam logic [9:0] DIV_64_LAST = 10'h03f;
    localparam logic [9:0] DIV_1024_LAST = 10'h3ff;
    // =====================================================================
    // Bus request carrier
    // =====================================================================
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } bus_req_t;
endpackage

// ### logic/prescaler.sv
// Purpose: Interval divider giving a one-cycle tick per selected interval.
// Assumes: Restart is a one-cycle pulse from a timer write.
// Notes: After restart the first tick comes one full interval later.
`timescale 1ns/1ps
module prescaler
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_restart,
    input wire logic [1:0] i_div,
    output logic o_tick
);
    logic [riot_pkg::PRESCALE_W-1:0] cnt_ff;
    logic [riot_pkg::PRESCALE_W-1:0] last;
    logic at_last;

    assign last = (i_div == riot_pkg::DIV_1) ? riot_pkg::DIV_1_LAST :
                  (i_div == riot_pkg::DIV_8) ? riot_pkg::DIV_8_LAST :
                  (i_div == riot_pkg::DIV_64) ? riot_pkg::DIV_64_LAST :
                  riot_pkg::DIV_1024_LAST;
    assign at_last = (cnt_ff == last);
    assign o_tick = at_last && !i_restart;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst || i_restart || at_last)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + 10'h001;
    end
endmodule // prescaler

// ### logic/edge_sense.sv
// Purpose: Synchronise the port A bit 7 pin and flag its chosen transition.
// Assumes: Pin is asynchronous to i_clk.
// Notes: Detection runs during reset too, since reset only forces falling mode.
`timescale 1ns/1ps
module edge_sense
(
    input wire logic i_clk,
    input wire logic i_pin,
    input wire logic i_rising,
    output logic o_level,
    output logic o_edge
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // No reset here so that an edge during reset is still seen.
    always_ff @(posedge i_clk)
    begin
        meta_ff <= i_pin;
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
    end

    assign o_level = sync_ff;
    assign o_edge = i_rising ? (sync_ff && !prev_ff) : (!sync_ff && prev_ff);
endmodule // edge_sense

// ### logic/interval_timer_edge_irq.sv
// Purpose: I/O port, interval timer and edge interrupt section of a RAM/I/O/timer chip.
// Assumes: Bus signals are synchronous to i_clk; one access per asserted strobe cycle.
// Notes: RAM array is outside; only its select is decoded here.
// Operation
// - Timer write latches prescale choice from A1 and A0.
// - Written byte loads 8-bit down counter, decremented each interval.
// - From zero, next tick sets timer flag and counter reads all ones.
// - After flag sets, counter decrements every clock.
// - Timer access latches A3 as timer interrupt enable; flag then pulls interrupt low.
// - Timeout sets timer flag bit 7 regardless of enable.
// - Timer read or write clears timer flag and interrupt.
// - Timer read in timeout cycle leaves the flag set.
// - Timer read before timeout returns remaining interval count.
// - Flag read puts timer flag on bit 7, edge flag on bit 6.
// - Flag register read clears edge flag unless an active edge arrives in the same cycle.
// - Active edge on port A bit 7 sets edge flag in any direction.
// - Edge flag with edge enable drives interrupt low.
// - Edge control write ignores data; A1 enables, A0 picks rising edge.
// - Reset disables edge interrupt and selects falling; edges still flag.
// - Respond only with high select set and low select clear; RAM select picks section.
// - A2 high selects timer, low selects port registers.
// - A1,A0 pick port A out, A direction, B out, B direction.
// - Interrupt output is active low open drain.
// - Reset clears port registers, all pins input, interrupts disabled.
// - Direction zero makes input; one drives the output register bit.
// - Port A read returns pins; port B read returns output register.
`timescale 1ns/1ps
module interval_timer_edge_irq
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_rw,
    input wire logic i_chip_select_high,
    input wire logic i_chip_select_low_n,
    input wire logic i_ram_select_n,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_ram_select,
    input wire logic [7:0] i_port_a,
    output logic [7:0] o_port_a,
    output logic [7:0] o_port_a_oe,
    input wire logic [7:0] i_port_b,
    output logic [7:0] o_port_b,
    output logic [7:0] o_port_b_oe,
    output logic o_irq_n,
    output logic o_irq_oe
);
    // =====================================================================
    // Address decode
    // =====================================================================
    riot_pkg::bus_req_t req;
    logic chip_sel;
    logic io_sel;
    logic timer_sel;
    logic port_sel;
    logic timer_wr;
    logic edge_wr;
    logic timer_rd;
    logic flag_rd;
    logic timer_access;
    logic [1:0] port_idx;
    logic port_wr;
    logic port_rd;

    assign req.read = i_rw;
    assign req.write = !i_rw;
    assign req.addr = i_addr;
    assign req.wdata = i_data;

    assign chip_sel = i_chip_select_high && !i_chip_select_low_n;
    assign o_ram_select = chip_sel && !i_ram_select_n;
    assign io_sel = chip_sel && i_ram_select_n;
    assign timer_sel = io_sel && req.addr[riot_pkg::A2_BIT];
    assign port_sel = io_sel && !req.addr[riot_pkg::A2_BIT];
    assign timer_wr = timer_sel && req.write && req.addr[riot_pkg::A4_BIT];
    assign edge_wr = timer_sel && req.write && !req.addr[riot_pkg::A4_BIT];
    assign timer_rd = timer_sel && req.read && !req.addr[riot_pkg::A0_BIT];
    assign flag_rd = timer_sel && req.read && req.addr[riot_pkg::A0_BIT];
    assign timer_access = timer_wr || timer_rd;
    assign port_idx = req.addr[riot_pkg::A1_BIT:riot_pkg::A0_BIT];
    assign port_wr = port_sel && req.write;
    assign port_rd = port_sel && req.read;

    // =====================================================================
    // Port registers
    // =====================================================================
    logic [7:0] port_a_output_ff;
    logic [7:0] port_a_direction_ff;
    logic [7:0] port_b_output_ff;
    logic [7:0] port_b_direction_ff;
    logic [7:0] port_a_sync1_ff;
    logic [7:0] port_a_sync2_ff;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            port_a_output_ff <= riot_pkg::PORT_RESET;
            port_a_direction_ff <= riot_pkg::PORT_RESET;
            port_b_output_ff <= riot_pkg::PORT_RESET;
            port_b_direction_ff <= riot_pkg::PORT_RESET;
        end
        else if (port_wr)
        begin
            unique case (port_idx)
                riot_pkg::SEL_PORT_A_OUTPUT: port_a_output_ff <= req.wdata;
                riot_pkg::SEL_PORT_A_DIRECTION: port_a_direction_ff <= req.wdata;
                riot_pkg::SEL_PORT_B_OUTPUT: port_b_output_ff <= req.wdata;
                riot_pkg::SEL_PORT_B_DIRECTION: port_b_direction_ff <= req.wdata;
            endcase
        end
    end

    // Port A pins are asynchronous, so they pass two flops before a read.
    always_ff @(posedge i_clk)
    begin
        port_a_sync1_ff <= i_port_a;
        port_a_sync2_ff <= port_a_sync1_ff;
    end

    assign o_port_a = port_a_output_ff;
    assign o_port_a_oe = port_a_direction_ff;
    assign o_port_b = port_b_output_ff;
    assign o_port_b_oe = port_b_direction_ff;

    // =====================================================================
    // Edge sense on port A bit 7
    // =====================================================================
    logic edge_enable_ff;
    logic edge_rising_ff;
    logic edge_flag_ff;
    logic edge_hit;

    edge_sense u_edge_sense
    (
        .i_clk(i_clk),
        .i_pin(i_port_a[7]),
        .i_rising(edge_rising_ff),
        .o_level(),
        .o_edge(edge_hit)
    );

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            edge_enable_ff <= 1'b0;
            edge_rising_ff <= 1'b0;
        end
        else if (edge_wr)
        begin
            edge_enable_ff <= req.addr[riot_pkg::A1_BIT];
            edge_rising_ff <= req.addr[riot_pkg::A0_BIT];
        end
    end

    // The flag keeps running through reset so a falling edge there is kept.
    always_ff @(posedge i_clk)
    begin
        if (edge_hit)
            edge_flag_ff <= 1'b1;
        else if (flag_rd)
            edge_flag_ff <= 1'b0;
    end

    // =====================================================================
    // Interval timer
    // =====================================================================
    logic [7:0] count_ff;
    logic [1:0] div_ff;
    logic timer_flag_ff;
    logic timer_enable_ff;
    logic tick;
    logic step;
    logic timeout;

    prescaler u_prescaler
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(timer_wr),
        .i_div(timer_wr ? req.addr[riot_pkg::A1_BIT:riot_pkg::A0_BIT] : div_ff),
        .o_tick(tick)
    );

    assign step = timer_flag_ff ? 1'b1 : tick;
    assign timeout = !timer_flag_ff && tick && (count_ff == 8'h00);

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            count_ff <= riot_pkg::COUNT_RESET;
            div_ff <= riot_pkg::PRESCALE_RESET;
        end
        else if (timer_wr)
        begin
            count_ff <= req.wdata;
            div_ff <= req.addr[riot_pkg::A1_BIT:riot_pkg::A0_BIT];
        end
        else if (step)
            count_ff <= count_ff - 8'h01;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            timer_enable_ff <= 1'b0;
        else if (timer_access)
            timer_enable_ff <= req.addr[riot_pkg::A3_BIT];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            timer_flag_ff <= 1'b0;
        else if (timeout)
            timer_flag_ff <= 1'b1;
        else if (timer_access)
            timer_flag_ff <= 1'b0;
    end

    // =====================================================================
    // Read data and interrupt
    // =====================================================================
    logic [7:0] flags;
    logic [7:0] port_rdata;
    logic [7:0] nxt_data;
    logic [7:0] data_ff;
    logic oe_ff;
    logic rd_any;

    assign flags = {timer_flag_ff, edge_flag_ff, 6'h00};
    assign port_rdata = (port_idx == riot_pkg::SEL_PORT_A_OUTPUT) ? port_a_sync2_ff :
                        (port_idx == riot_pkg::SEL_PORT_A_DIRECTION) ? port_a_direction_ff :
                        (port_idx == riot_pkg::SEL_PORT_B_OUTPUT) ? port_b_output_ff :
                        port_b_direction_ff;
    assign rd_any = port_rd || timer_rd || flag_rd;
    assign nxt_data = port_rd ? port_rdata :
                      timer_rd ? count_ff :
                      flag_rd ? flags : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            data_ff <= 8'h00;
            oe_ff <= 1'b0;
        end
        else
        begin
            data_ff <= nxt_data;
            oe_ff <= rd_any;
        end
    end

    assign o_data = data_ff;
    assign o_data_oe = oe_ff;
    // Open drain: the output only ever pulls low, never drives high.
    assign o_irq_n = 1'b0;
    assign o_irq_oe = (timer_flag_ff && timer_enable_ff) || (edge_flag_ff && edge_enable_ff);

    // =====================================================================
    // Checks
    // =====================================================================
    a_flag_sets_timeout: assert property (@(posedge i_clk) disable iff (!i_nrst)
        timeout |=> timer_flag_ff && count_ff == 8'hff)
        else $error("Timer flag or wrap value missing after timeout.");
    a_access_clears_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (timer_access && !timeout) |=> !timer_flag_ff)
        else $error("Timer access did not clear the flag.");
    a_post_timeout_rate: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (timer_flag_ff && !timer_access) |=> count_ff == $past(count_ff) - 8'h01)
        else $error("Counter not decrementing every clock after timeout.");
    a_write_loads_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
        timer_wr |=> count_ff == $past(i_data) && !timer_flag_ff)
        else $error("Timer write did not load the counter.");
    a_edge_flag_set: assert property (@(posedge i_clk)
        edge_hit |=> edge_flag_ff)
        else $error("Edge did not set the edge flag.");
    a_flag_read_clears: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (flag_rd && !edge_hit) |=> !edge_flag_ff)
        else $error("Flag read did not clear edge flag.");
    a_irq_timer_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (timer_flag_ff && !timer_enable_ff && !(edge_flag_ff && edge_enable_ff)) |-> !o_irq_oe)
        else $error("Interrupt driven while timer interrupt disabled.");
    a_edge_ctrl_reset: assert property (@(posedge i_clk)
        !i_nrst |=> !edge_enable_ff && !edge_rising_ff)
        else $error("Reset did not restore edge control.");
    a_no_sel_no_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !io_sel |=> !o_data_oe)
        else $error("Data driven without section select.");
    a_restart_full_interval: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (timer_wr && req.addr[riot_pkg::A1_BIT:riot_pkg::A0_BIT] == riot_pkg::DIV_8)
            ##1 !timer_wr [*8] |-> tick)
        else $error("First prescaler tick not one full interval after a timer write.");
endmodule // interval_timer_edge_irq

// ### tb/cpu_bus_model.sv
// Purpose: Processor model that runs single bus cycles on the block.
// Assumes: Signals change on the falling edge; the block samples on the rising one.
// Notes: A released data bus shows the inverse of the last byte, never a stale copy.
`timescale 1ns/1ps
module cpu_bus_model
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rdata_oe,
    input wire logic i_ram_select,
    output logic o_rw,
    output logic o_cs_high,
    output logic o_cs_low_n,
    output logic o_ram_select_n,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);
    // =====================================================================
    // Idle bus
    // =====================================================================
    initial
    begin
        o_rw = 1'b1;
        o_cs_high = 1'b0;
        o_cs_low_n = 1'b1;
        o_ram_select_n = 1'b1;
        o_addr = 7'h00;
        o_wdata = 8'h00;
    end
    // =====================================================================
    // One access, held for exactly one sampling edge
    // =====================================================================
    task automatic access(input logic rw, input logic ram, input logic sel,
        input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
        output logic oe, output logic rs);
        @(negedge i_clk);
        o_rw = rw;
        o_cs_high = sel;
        o_cs_low_n = ~sel;
        o_ram_select_n = ~ram;
        o_addr = a;
        o_wdata = d;
        #1;
        rs = i_ram_select;
        @(negedge i_clk);
        q = i_rdata;
        oe = i_rdata_oe;
        o_cs_high = 1'b0;
        o_cs_low_n = 1'b1;
        o_rw = 1'b1;
        o_wdata = ~d;
    endtask
endmodule // cpu_bus_model

// ### tb/interval_timer_edge_irq_tb.sv
// Purpose: Self-checking bench for the port, timer and edge interrupt block.
// Assumes: Bus cycles come from the processor model; inputs move on falling edges.
// Notes: Timeout moment is accepted within one cycle of the nominal figure.
`timescale 1ns/1ps
module interval_timer_edge_irq_tb;
    logic clk, nrst, rw, cs_high, cs_low_n, ram_sel_n, rdata_oe, ram_sel;
    logic irq_n, irq_oe, irq_line;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, pa_in, pa_out, pa_oe, pb_out, pb_oe;
    int mismatches = 0;
    int checks_done = 0;
    // The interrupt line has a pull-up; the block only pulls it low.
    assign irq_line = irq_oe ? irq_n : 1'b1;
    interval_timer_edge_irq u_dut (.i_clk(clk), .i_nrst(nrst), .i_rw(rw),
        .i_chip_select_high(cs_high), .i_chip_select_low_n(cs_low_n),
        .i_ram_select_n(ram_sel_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
        .o_data_oe(rdata_oe), .o_ram_select(ram_sel), .i_port_a(pa_in),
        .o_port_a(pa_out), .o_port_a_oe(pa_oe), .i_port_b(8'h00), .o_port_b(pb_out),
        .o_port_b_oe(pb_oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe));
    cpu_bus_model u_cpu (.i_clk(clk), .i_rdata(rdata), .i_rdata_oe(rdata_oe),
        .i_ram_select(ram_sel), .o_rw(rw), .o_cs_high(cs_high), .o_cs_low_n(cs_low_n),
        .o_ram_select_n(ram_sel_n), .o_addr(addr), .o_wdata(wdata));
    // =====================================================================
    // Clock, comparisons and bus shorthands
    // =====================================================================
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        logic oe;
        logic rs;
        u_cpu.access(1'b1, 1'b0, 1'b1, a, 8'h00, q, oe, rs);
        check_bit("read drive", 1'b1, oe);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic oe;
        logic rs;
        u_cpu.access(1'b0, 1'b0, 1'b1, a, d, q, oe, rs);
    endtask
    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic test_reset();
        logic [7:0] q;
        check_byte("port a enable", 8'h00, pa_oe);
        check_byte("port b enable", 8'h00, pb_oe);
        for (int i = 1; i < 4; i++)
        begin
            rd(7'(i), q);
            check_byte("port reg reset", 8'h00, q);
        end
        rd(7'h05, q);
        pa_in[7] = 1'b0;
        repeat (6) @(negedge clk);
        check_bit("irq after reset", 1'b1, irq_line);
        rd(7'h05, q);
        check_bit("falling edge flag", 1'b1, q[6]);
    endtask
    task automatic test_ports();
        logic [7:0] q;
        logic oe;
        logic rs;
        logic [7:0] val [4] = '{8'h5a, 8'hf0, 8'h3c, 8'h0f};
        for (int i = 0; i < 4; i++)
            wr(7'(i), val[i]);
        check_byte("port a out", 8'h5a, pa_out);
        check_byte("port a dir", 8'hf0, pa_oe);
        check_byte("port b out", 8'h3c, pb_out);
        check_byte("port b dir", 8'h0f, pb_oe);
        for (int i = 1; i < 4; i++)
        begin
            rd(7'(i), q);
            check_byte("port reg", val[i], q);
        end
        pa_in = 8'h66;
        repeat (3) @(negedge clk);
        rd(7'h00, q);
        check_byte("port a pins", 8'h66, q);
        u_cpu.access(1'b1, 1'b1, 1'b1, 7'h02, 8'h00, q, oe, rs);
        check_bit("ram select", 1'b1, rs);
        check_bit("ram read quiet", 1'b0, oe);
        u_cpu.access(1'b0, 1'b0, 1'b0, 7'h02, 8'hff, q, oe, rs);
        check_bit("no ram select", 1'b0, rs);
        check_byte("unselected write", 8'h3c, pb_out);
    endtask
    task automatic test_timer(input logic [1:0] div, input logic [7:0] cnt, input int per,
        input logic en);
        logic [7:0] q;
        time t0;
        int n;
        int exp;
        // The write restarts the prescaler, so the flag sets one interval after zero is reached.
        exp = (int'(cnt) + 1) * per;
        wr({2'h0, 1'b1, en, 1'b1, div}, cnt);
        t0 = $time;
        if (per == 1024)
        begin
            rd({3'h0, en, 3'h4}, q);
            check_byte("remaining count", cnt, q);
        end
        if (en)
        begin
            while (irq_line !== 1'b0 && ($time - t0) < 4 * (exp + 4))
                @(negedge clk);
            n = int'(($time - t0) / 4);
            check_bit("timeout moment", 1'b1, n >= exp - 1 && n <= exp + 1);
        end
        else
        begin
            repeat (exp + 2) @(negedge clk);
            check_bit("masked timer irq", 1'b1, irq_line);
        end
        rd(7'h05, q);
        check_bit("timer flag", 1'b1, q[7]);
        rd(7'h04, q);
        if (en)
            check_byte("count after timeout", 8'hfc, q);
        else
            check_bit("count after timeout", 1'b1, q[7]);
        check_bit("timer irq released", 1'b1, irq_line);
        rd(7'h05, q);
        check_bit("timer flag cleared", 1'b0, q[7]);
    endtask
    task automatic test_edge(input logic rising, input logic en);
        logic [7:0] q;
        pa_in[7] = ~rising;
        wr({5'h01, en, rising}, 8'hff);
        repeat (4) @(negedge clk);
        rd(7'h05, q);
        check_bit("no stale edge", 1'b1, irq_line);
        pa_in[7] = rising;
        repeat (5) @(negedge clk);
        check_bit("edge irq", ~en, irq_line);
        rd(7'h05, q);
        check_bit("edge flag", 1'b1, q[6]);
        rd(7'h05, q);
        check_bit("edge flag cleared", 1'b0, q[6]);
    endtask
    // =====================================================================
    // Main sequence and watchdog
    // =====================================================================
    initial
    begin
        pa_in = 8'h81;
        nrst = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        test_reset();
        test_ports();
        test_timer(riot_pkg::DIV_1, 8'h05, 1, 1'b1);
        test_timer(riot_pkg::DIV_8, 8'h03, 8, 1'b1);
        test_timer(riot_pkg::DIV_64, 8'h02, 64, 1'b0);
        test_timer(riot_pkg::DIV_1024, 8'h01, 1024, 1'b1);
        for (int i = 0; i < 4; i++)
            test_edge(i[0], i[1]);
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule // interval_timer_edge_irq_tb
